// File: verilog/tof_seq_pkg.sv
// Purpose: Shared constants for the time-of-flight modulation sequencer
// Assumes: Registers are written through a simple synchronous write/read port
// Notes:   Divider encodings 0,1,3,7,15 are the documented settings
package tof_seq_pkg;
   // ----------------------------------------
   // Register offsets and reset values
   // ----------------------------------------
   localparam logic [7:0] MOD_CLOCK_DIVIDER_ADDR = 8'h85;
   localparam logic [7:0] SAMPLE_READOUT_COUNT_ADDR = 8'h92;
   localparam logic [7:0] SHUTTER_COMMAND_ADDR = 8'h93;
   localparam logic [7:0] SEQ_STATUS_ADDR = 8'h94;
   localparam logic [7:0] INT_TIME_LO_ADDR = 8'ha2;
   localparam logic [7:0] INT_TIME_HI_ADDR = 8'ha3;
   localparam logic [7:0] MOD_CLOCK_DIVIDER_RST = 8'h01;
   localparam logic [7:0] SAMPLE_READOUT_COUNT_RST = 8'h03;
   // Readout count field: 00 one sample, 01 two, 11 four
   localparam int COUNT_FIELD_LSB = 0;
   localparam logic [1:0] COUNT_ONE = 2'h0;
   localparam logic [1:0] COUNT_TWO = 2'h1;
   localparam logic [1:0] COUNT_FOUR = 2'h3;
   localparam int SHUTTER_BIT = 0;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 125;
   // Base integration tick 10.4 ns at divider 0; default 47.6 us -> 4576 base ticks, stored as 2288 steps x2
   localparam int INT_TIME_NS_X10 = 476000;
   localparam int INT_UNIT_NS_X10 = 104;
   localparam logic [15:0] INT_TIME_RST = 16'(INT_TIME_NS_X10 / INT_UNIT_NS_X10 / 2);
   localparam int GAP_NS = 80;
   localparam int GAP_CYCLES = (GAP_NS * CLK_MHZ + 999) / 1000;
   // Modulation period in modulator ticks: 4 ticks per illumination cycle
   localparam int TICKS_PER_PERIOD = 4;
endpackage

// File: verilog/tof_phase_gen.sv
// Purpose: Quarter-phase square wave generator for drive and gates
// Assumes: tick_i pulses once per modulator clock period
// Notes:   Four ticks make one illumination period
`timescale 1ns/1ps
module tof_phase_gen (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic run_i,
   input wire logic tick_i,
   input wire logic [1:0] sample_i,
   output logic illum_o,
   output logic gate_a_o,
   output logic gate_b_o
);
   logic [1:0] quarter_q;
   logic [1:0] quarter_d;
   logic ref_wave;
   logic led_wave;
   logic [1:0] led_q;
   logic swap;

   // ----------------------------------------
   // Quarter counter
   // ----------------------------------------
   assign quarter_d = run_i ? (tick_i ? quarter_q + 2'h1 : quarter_q) : 2'h0;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         quarter_q <= 2'h0;
      end else begin
         quarter_q <= quarter_d;
      end
   end

   // Both waves are high half the period, so duty is exactly even
   assign ref_wave = ~quarter_q[1];
   // Sample 1 and 3 delay the drive by one quarter; 2 and 3 swap gates
   assign led_q = quarter_q - {1'b0, sample_i[0]};
   assign led_wave = ~led_q[1];
   assign swap = sample_i[1];

   // Drive and both gates come from one counter
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         illum_o <= 1'b0;
         gate_a_o <= 1'b0;
         gate_b_o <= 1'b0;
      end else begin
         illum_o <= run_i & led_wave;
         gate_a_o <= run_i & (swap ? ~ref_wave : ref_wave);
         gate_b_o <= run_i & (swap ? ref_wave : ~ref_wave);
      end
   end

endmodule // tof_phase_gen

// File: verilog/tof_modulation_distance_sequencer.sv
// Purpose: Shutter-triggered sequencer of correlation sample acquisitions
// Assumes: Register port is a synchronous single-cycle write/read
// Notes:   Host-side distance math is outside this block
//
// Functional notes
// - Illumination drive is a 50 percent square wave.
// - Reset defaults: divider 1, 12 MHz drive, four samples, 47.6 us.
// - One modulator makes drive and all gates together.
// - End of the whole sequence, after the last sample's gap, is marked by a falling frame sync.
// - Pin or register shutter starts the programmed sample count.
// - Drive phase per sample 0, 90, 180, 270 versus gate A.
// - Samples 2 and 3 swap gates A and B.
// - Count field 01 gives exactly two samples per shutter.
// - Divider sets modulator clock 96 MHz over (divider+1).
// - Integration time base scales with divider plus one.
`timescale 1ns/1ps
module tof_modulation_distance_sequencer #(
   parameter int INT_W = 16
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic mod_tick_i,
   input wire logic shutter_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic illum_o,
   output logic gate_a_o,
   output logic gate_b_o,
   output logic frame_sync_o,
   output logic busy_o
);
   initial begin
      if (INT_W < 16 || INT_W > 24) $error("INT_W out of range");
   end

   typedef enum logic [1:0] {IDLE, INTEG, GAP} seq_e;

   seq_e state_q, state_d;
   logic [7:0] divider_q;
   logic [7:0] count_reg_q;
   logic [15:0] int_time_q;
   logic [7:0] div_cnt_q;
   logic [1:0] sample_q;
   logic [1:0] last_sample;
   logic [INT_W-1:0] int_cnt_q;
   logic [7:0] gap_cnt_q;
   logic int_last;
   logic mod_en;
   logic base_tick;
   logic start;
   logic sw_shutter;
   logic run;

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction

   assign sw_shutter = reg_wr_i & hit(reg_addr_i, tof_seq_pkg::SHUTTER_COMMAND_ADDR)
                       & reg_wdata_i[tof_seq_pkg::SHUTTER_BIT];
   // Either trigger source starts a sequence when idle
   assign start = (state_q == IDLE) & (shutter_i | sw_shutter);

   // Writes during acquisition still land; host keeps them out of frames
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         divider_q <= tof_seq_pkg::MOD_CLOCK_DIVIDER_RST;
         count_reg_q <= tof_seq_pkg::SAMPLE_READOUT_COUNT_RST;
         int_time_q <= tof_seq_pkg::INT_TIME_RST;
      end else if (reg_wr_i) begin
         if (hit(reg_addr_i, tof_seq_pkg::MOD_CLOCK_DIVIDER_ADDR)) divider_q <= reg_wdata_i;
         if (hit(reg_addr_i, tof_seq_pkg::SAMPLE_READOUT_COUNT_ADDR)) count_reg_q <= reg_wdata_i;
         if (hit(reg_addr_i, tof_seq_pkg::INT_TIME_LO_ADDR)) int_time_q[7:0] <= reg_wdata_i;
         if (hit(reg_addr_i, tof_seq_pkg::INT_TIME_HI_ADDR)) int_time_q[15:8] <= reg_wdata_i;
      end
   end

   // Read mux, unmapped offsets read zero
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            tof_seq_pkg::MOD_CLOCK_DIVIDER_ADDR: reg_rdata_o <= divider_q;
            tof_seq_pkg::SAMPLE_READOUT_COUNT_ADDR: reg_rdata_o <= count_reg_q;
            tof_seq_pkg::SEQ_STATUS_ADDR: reg_rdata_o <= {4'h0, sample_q, 1'b0, busy_o};
            tof_seq_pkg::INT_TIME_LO_ADDR: reg_rdata_o <= int_time_q[7:0];
            tof_seq_pkg::INT_TIME_HI_ADDR: reg_rdata_o <= int_time_q[15:8];
            default: reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // Modulator clock divider
   // ----------------------------------------
   // mod_tick_i runs at 96 MHz equivalent; divider+1 ticks make one step
   assign mod_en = mod_tick_i & (div_cnt_q == divider_q);

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_cnt_q <= 8'h00;
      end else if (!run) begin
         // Restart each integration on a step boundary, so every sample sees whole modulator steps
         div_cnt_q <= 8'h00;
      end else if (mod_tick_i) begin
         div_cnt_q <= (div_cnt_q == divider_q) ? 8'h00 : div_cnt_q + 8'h01;
      end
   end

   // Integration base advances per modulator step, so it stretches with the divider
   // Only steps inside integration count towards its length
   assign base_tick = mod_en & run;
   // Last step of integration; a zero setting still gives one step rather than a wrap
   assign int_last = (int_cnt_q + INT_W'(1)) >= INT_W'(int_time_q);

   // ----------------------------------------
   // Sequence control
   // ----------------------------------------
   // Last sample index: 0, 1 or 3 from the count field
   assign last_sample = (count_reg_q[1:0] == tof_seq_pkg::COUNT_TWO) ? 2'h1 :
                        (count_reg_q[1:0] == tof_seq_pkg::COUNT_ONE) ? 2'h0 : 2'h3;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         IDLE: if (start) state_d = INTEG;
         INTEG: if (base_tick && int_last) state_d = GAP;
         GAP: begin
            if (gap_cnt_q == 8'(tof_seq_pkg::GAP_CYCLES)) begin
               state_d = (sample_q == last_sample) ? IDLE : INTEG;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= IDLE;
         sample_q <= 2'h0;
         int_cnt_q <= '0;
         gap_cnt_q <= 8'h00;
      end else begin
         state_q <= state_d;
         if (start) sample_q <= 2'h0;
         else if (state_q == GAP && state_d == INTEG) sample_q <= sample_q + 2'h1;
         int_cnt_q <= (state_q != INTEG) ? '0 : (base_tick ? int_cnt_q + INT_W'(1) : int_cnt_q);
         gap_cnt_q <= (state_q != GAP) ? 8'h00 : gap_cnt_q + 8'h01;
      end
   end

   assign busy_o = state_q != IDLE;
   assign run = state_q == INTEG;

   // Frame sync high during the sequence; its fall marks the end of the last sample's gap
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         frame_sync_o <= 1'b0;
      end else begin
         frame_sync_o <= (state_d != IDLE);
      end
   end

   // ----------------------------------------
   // Waveform generator
   // ----------------------------------------
   tof_phase_gen u_phase (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .run_i(run),
      .tick_i(mod_en),
      .sample_i(sample_q),
      .illum_o(illum_o),
      .gate_a_o(gate_a_o),
      .gate_b_o(gate_b_o)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence start_s;
      start;
   endsequence

   // Gate A follows the reference for samples 0 and 1, its inverse for 2 and 3
   sequence swapped_s;
      run && sample_q[1];
   endsequence

   start_busy_a: assert property (start_s |=> busy_o) else $error("no start");
   sync_fall_a: assert property ($fell(frame_sync_o) |-> !busy_o) else $error("sync");
   two_count_a: assert property (busy_o && count_reg_q[1:0] == 2'h1 |-> sample_q <= 2'h1)
      else $error("two");
   swap_gate_a: assert property (swapped_s |=> gate_a_o == $past(u_phase.quarter_q[1]))
      else $error("swap");
   plain_gate_a: assert property (run && !sample_q[1] |=> gate_a_o == !$past(u_phase.quarter_q[1]))
      else $error("plain gate");
   gates_excl_a: assert property (!(gate_a_o && gate_b_o)) else $error("gates");
   idle_dark_a: assert property (!run |=> !illum_o) else $error("dark");
   div_wrap_a: assert property (mod_en |=> div_cnt_q == 8'h00 || !$past(mod_tick_i))
      else $error("div");
   // Divider 1 must stretch each step to two clocks
   base_tick_a: assert property (mod_en && run && divider_q == 8'h01 |=> !mod_en)
      else $error("base");
   phase_a: assert property (run |-> sample_q <= last_sample) else $error("phase");
   rst_def_a: assert property ($fell(sys_rst_i) |-> divider_q == 8'h01) else $error("rst");
endmodule // tof_modulation_distance_sequencer

// File: test/tof_host_model.sv
// Purpose: Host controller model driving shutter and register port
// Assumes: Register writes take effect at the edge where the strobe is high
// Notes:   Address shows inverted values once either strobe is released, write data only once the write strobe is
`timescale 1ns/1ps
module tof_host_model (
   input wire logic clk_i,
   input wire logic frame_sync_i,
   input wire logic [7:0] rdata_i,
   output logic shutter_o,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   initial begin
      shutter_o = 1'b0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   // Writes only between frames, well inside the update window
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   // Read data is taken one cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_i);
      rd_o <= 1'b1;
      addr_o <= a;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      @(posedge clk_i);
      v = rdata_i;
   endtask
   // Unambiguity distance in millimetres, c over twice the drive frequency
   function automatic int unamb_mm(input int f_khz);
      return int'(299792458.0e3 / (2.0 * f_khz * 1.0e3));
   endfunction
   // Roll-over after the offset is added
   function automatic int roll_mm(input int d, input int u);
      if (d > u) return d - u;
      else if (d < 0) return d + u;
      else return d;
   endfunction
   // Distance in millimetres from signed samples, four or two sample form
   function automatic int dist_mm(input logic signed [11:0] s0, s1, s2, s3,
                                  input bit two, input int f_khz, input int off_mm);
      real y;
      real x;
      real d;
      y = two ? -real'(s1) : real'(s3) - real'(s1);
      x = two ? -real'(s0) : real'(s2) - real'(s0);
      d = (3.14159265358979 + $atan2(y, x)) * 299792458.0e3
          / (4.0 * 3.14159265358979 * f_khz * 1.0e3);
      return roll_mm(int'(d) + off_mm, unamb_mm(f_khz));
   endfunction
   // Received amplitude, half the length of the difference vector
   function automatic int amp_lsb(input logic signed [11:0] s0, s1, s2, s3);
      real a;
      real b;
      a = real'(s2) - real'(s0);
      b = real'(s3) - real'(s1);
      return int'($sqrt(a * a + b * b) / 2.0);
   endfunction
   // 0 too weak, 1 noisy, 2 good, 3 overexposed
   function automatic int amp_class(input int a);
      if (a < 25) return 0;
      else if (a < 100) return 1;
      else if (a <= 2000) return 2;
      else return 3;
   endfunction
   // Hardware shutter pulse of one cycle
   task automatic pulse();
      @(posedge clk_i);
      shutter_o <= 1'b1;
      @(posedge clk_i);
      shutter_o <= 1'b0;
   endtask
   // Update point is the falling frame sync, bounded wait
   task automatic wait_end();
      int k;
      for (k = 0; k < 20 && frame_sync_i !== 1'b1; k++) @(posedge clk_i);
      for (k = 0; k < 9000 && frame_sync_i !== 1'b0; k++) @(posedge clk_i);
      @(posedge clk_i);
   endtask
endmodule // tof_host_model

// File: test/tb.sv
// Purpose: Self-checking bench for the modulation sequencer
// Assumes: One modulator tick per clock, integration of 8 modulator steps
// Notes:   Waveform checks count cycles, so they tolerate any start phase
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] rdata;
   logic illum, gate_a, gate_b, fsync, busy, shut, wr, rd;
   logic [7:0] addr, wdata, v, dv, cv;
   logic [7:0] divs [5] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0f};
   int seed = 20093;
   int n_mismatch = 0;
   int num_checks = 0;
   int hi_cnt, ov_a, ov_b, falls, n, i;
   logic fs_q;
   logic mon_clr = 1'b0;
   always #4 clk = ~clk;
   tof_modulation_distance_sequencer tof_modulation_distance_sequencer_inst (
      .clk_i(clk), .sys_rst_i(rst), .mod_tick_i(1'b1), .shutter_i(shut),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .illum_o(illum), .gate_a_o(gate_a), .gate_b_o(gate_b),
      .frame_sync_o(fsync), .busy_o(busy));
   tof_host_model tof_host_model_inst (
      .clk_i(clk), .frame_sync_i(fsync), .rdata_i(rdata), .shutter_o(shut),
      .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
   // ----------------------------------------
   // Waveform monitor
   // ----------------------------------------
   // Overlap counts expose the phase of each gate against the drive
   always @(posedge clk) begin
      fs_q <= fsync;
      // Clearing here keeps a single writer, so no race with the main sequence
      if (mon_clr) begin
         hi_cnt <= 0;
         ov_a <= 0;
         ov_b <= 0;
         falls <= 0;
      end else begin
         hi_cnt <= hi_cnt + (illum === 1'b1);
         ov_a <= ov_a + (illum === 1'b1 && gate_a === 1'b1);
         ov_b <= ov_b + (illum === 1'b1 && gate_b === 1'b1);
         falls <= falls + (fs_q === 1'b1 && fsync === 1'b0);
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Drive high cycles: half of each modulator step count, scaled by divider plus one
   function automatic int exp_high(input int cnt, input int d);
      return cnt * 8 * (d + 1) / 2;
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      tof_host_model_inst.rd(tof_seq_pkg::MOD_CLOCK_DIVIDER_ADDR, v);
      check(v, 8'h01);
      tof_host_model_inst.rd(tof_seq_pkg::SAMPLE_READOUT_COUNT_ADDR, v);
      check(v, 8'h03);
      tof_host_model_inst.rd(8'h40, v);
      check(v, 8'h00);
      // Host math corner cases at 12 MHz drive
      check(tof_host_model_inst.unamb_mm(12000), 12491);
      check(tof_host_model_inst.dist_mm(-12'sd100, 12'sd0, 12'sd100, 12'sd0, 1'b0, 12000, 0),
            6246);
      check(tof_host_model_inst.dist_mm(-12'sd100, 12'sd0, 12'sd100, 12'sd0, 1'b0, 12000, 7000),
            755);
      check(tof_host_model_inst.dist_mm(-12'sd100, 12'sd0, 12'sd100, 12'sd0, 1'b0, 12000, -7000),
            11737);
      check(tof_host_model_inst.dist_mm(-12'sd50, 12'sd0, 12'sd0, 12'sd0, 1'b1, 12000, 0),
            6246);
      check(tof_host_model_inst.amp_lsb(-12'sd30, -12'sd40, 12'sd30, 12'sd40), 50);
      check(tof_host_model_inst.amp_class(10), 0);
      check(tof_host_model_inst.amp_class(50), 1);
      check(tof_host_model_inst.amp_class(500), 2);
      check(tof_host_model_inst.amp_class(3000), 3);
      tof_host_model_inst.wr(tof_seq_pkg::INT_TIME_LO_ADDR, 8'h08);
      tof_host_model_inst.wr(tof_seq_pkg::INT_TIME_HI_ADDR, 8'h00);
      // Each listed divider then random ones, count alternating, trigger source alternating in pairs
      for (i = 0; i < 8; i++) begin
         dv = (i < 5) ? divs[i] : divs[$unsigned($random(seed)) % 5];
         cv = i[0] ? {6'h00, tof_seq_pkg::COUNT_TWO} : {6'h00, tof_seq_pkg::COUNT_FOUR};
         n = i[0] ? 2 : 4;
         tof_host_model_inst.wr(tof_seq_pkg::MOD_CLOCK_DIVIDER_ADDR, dv);
         tof_host_model_inst.wr(tof_seq_pkg::SAMPLE_READOUT_COUNT_ADDR, cv);
         tof_host_model_inst.rd(tof_seq_pkg::MOD_CLOCK_DIVIDER_ADDR, v);
         check(v, dv);
         @(posedge clk);
         mon_clr <= 1'b1;
         @(posedge clk);
         mon_clr <= 1'b0;
         if (i[1]) begin
            tof_host_model_inst.pulse();
            repeat (3) @(posedge clk);
            check(busy, 1'b1);
            tof_host_model_inst.pulse();
         end else begin
            tof_host_model_inst.wr(tof_seq_pkg::SHUTTER_COMMAND_ADDR, 8'h01);
         end
         tof_host_model_inst.wait_end();
         repeat (2) @(posedge clk);
         check(hi_cnt, exp_high(n, dv));
         if (n == 2) check(ov_a, 3 * ov_b);
         else check(ov_a, ov_b);
         check(falls, 1);
         check(illum | gate_a | gate_b, 1'b0);
      end
      test_done();
   end
   initial begin
      hi_cnt = 0;
      ov_a = 0;
      ov_b = 0;
      falls = 0;
      fs_q = 1'b0;
      #400000;
      n_mismatch++;
      test_done();
   end
endmodule // tb
